// file: scc_params.svh
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
// address and data widths
`define SCC_AW       32
`define SCC_DW       32
// two ways, 16 sets, four words (16 bytes) to a line
`define SCC_WAYS     2
`define SCC_WAY_W    1
`define SCC_SETS     16
`define SCC_IDX_W    4
`define SCC_WORDS    4
`define SCC_OFF_W    2
`define SCC_TAG_W    24
// address field positions
`define SCC_OFF_LSB  2
`define SCC_IDX_LSB  4
`define SCC_TAG_LSB  8
// data store indexing
`define SCC_DIDX_W   7
`define SCC_DEPTH    128
// constants of the line walk
`define SCC_OFF_LAST 2'h3
`define SCC_OFF_ZERO 2'h0
`define SCC_BYTE0    2'h0
`endif

// file: scc_pkg.sv
`include "scc_params.svh"
package scc_pkg;
    // --------------------
    // controller states
    // --------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_WT   = 5'h02,
        ST_WB   = 5'h04,
        ST_FILL = 5'h08,
        ST_DONE = 5'h10
    } scc_state_e;
    typedef logic [`SCC_TAG_W-1:0] scc_tag_t;
endpackage

// file: scc_way_match.sv
`timescale 1ns/10ps
`include "scc_params.svh"
module scc_way_match (
    input  wire logic [`SCC_WAYS*`SCC_TAG_W-1:0] tags_flat,
    input  wire logic [`SCC_WAYS-1:0]            valid_vec,
    input  wire scc_pkg::scc_tag_t               tag,
    output logic                                 hit,
    output logic [`SCC_WAY_W-1:0]                hit_way
);
    logic [`SCC_WAYS-1:0] match;

    // --------------------
    // per-way tag compare
    // --------------------
    genvar g;
    generate
        for (g = 0; g < `SCC_WAYS; g++) begin : g_cmp
            // invalid entries never match
            assign match[g] = valid_vec[g] && (tags_flat[g*`SCC_TAG_W +: `SCC_TAG_W] == tag);
        end
    endgenerate

    assign hit = |match;

    // encode matching way, at most one is set
    always_comb begin
        hit_way = '0;
        for (int i = 0; i < `SCC_WAYS; i++) begin
            if (match[i]) begin
                hit_way = `SCC_WAY_W'(i);
            end
        end
    end
endmodule

// file: scc_lru.sv
`timescale 1ns/10ps
`include "scc_params.svh"
module scc_lru (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_sync_n,
    input  wire logic                  touch,
    input  wire logic [`SCC_IDX_W-1:0] touch_idx,
    input  wire logic [`SCC_WAY_W-1:0] touch_way,
    input  wire logic [`SCC_IDX_W-1:0] look_idx,
    input  wire logic [`SCC_WAYS-1:0]  look_valid,
    output logic [`SCC_WAY_W-1:0]      victim_way
);
    // most recently used way per set; two ways only
    logic [`SCC_SETS-1:0] mru_r;

    // --------------------
    // recency tracking
    // --------------------
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mru_r <= '0;
        end else if (touch) begin
            mru_r[touch_idx] <= touch_way[0];
        end
    end

    // empty way first, so valid lines are not thrown out needlessly
    always_comb begin
        if (!look_valid[0]) begin
            victim_way = 1'b0;
        end else if (!look_valid[1]) begin
            victim_way = 1'b1;
        end else begin
            victim_way = ~mru_r[look_idx];
        end
    end
endmodule

// file: scc_ctrl.sv
`timescale 1ns/10ps
`include "scc_params.svh"
// Functional notes
// - every processor read compares its address with the tags of the set it maps to.
// - a read hit answers from the cache store and starts no memory cycle.
// - a read miss fetches the whole line from memory into the cache, then hits.
// - the snoop port is watched in every state, whatever the processor does.
// - a snooped write from another master to a cached line clears that line's valid bit.
// - a read or a copy-back write to a line cleared by snooping misses and refetches the line.
// - a policy input selects write-through or copy-back for each processor write.
// - in write-through mode a write hit updates the cache and memory in the same access.
// - in copy-back mode a write hit updates only the cache and releases the processor at once.
// - in copy-back mode memory is updated only when a modified line is evicted.
// - an eviction writes back every word of the 16-byte line, not only the changed ones.
module scc_ctrl (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              policy_copy_back,
    input  wire logic              cpu_req,
    input  wire logic              cpu_we,
    input  wire logic [`SCC_AW-1:0] cpu_addr,
    input  wire logic [`SCC_DW-1:0] cpu_wdata,
    output logic                   cpu_ready,
    output logic [`SCC_DW-1:0]     cpu_rdata,
    output logic                   mem_req,
    output logic                   mem_we,
    output logic [`SCC_AW-1:0]     mem_addr,
    output logic [`SCC_DW-1:0]     mem_wdata,
    input  wire logic              mem_ack,
    input  wire logic [`SCC_DW-1:0] mem_rdata,
    input  wire logic              snp_wr,
    input  wire logic [`SCC_AW-1:0] snp_addr
);
    // --------------------
    // reset release
    // --------------------
    logic rst_meta_r;
    logic rst_sync_n;

    // async assert, release through two flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // --------------------
    // storage
    // --------------------
    scc_pkg::scc_tag_t    tag_r   [0:`SCC_WAYS-1][0:`SCC_SETS-1];
    logic [`SCC_SETS-1:0] valid_r [0:`SCC_WAYS-1];
    logic [`SCC_SETS-1:0] dirty_r [0:`SCC_WAYS-1];
    logic [`SCC_DW-1:0]   data_r  [0:`SCC_DEPTH-1];

    // --------------------
    // sequencing state
    // --------------------
    scc_pkg::scc_state_e   state_r;
    logic [`SCC_OFF_W-1:0] cnt_r;
    logic [`SCC_WAY_W-1:0] vway_r;
    logic [`SCC_IDX_W-1:0] lidx_r;
    scc_pkg::scc_tag_t     ftag_r;
    logic                  stale_r;
    logic                  mem_req_r;
    logic                  mem_we_r;
    logic [`SCC_AW-1:0]    mem_addr_r;
    logic [`SCC_DW-1:0]    mem_wdata_r;
    logic [`SCC_DW-1:0]    cpu_rdata_r;

    // --------------------
    // address split
    // --------------------
    logic [`SCC_IDX_W-1:0] cpu_idx;
    logic [`SCC_OFF_W-1:0] cpu_off;
    scc_pkg::scc_tag_t     cpu_tag;
    logic [`SCC_IDX_W-1:0] snp_idx;
    scc_pkg::scc_tag_t     snp_tag;

    assign cpu_idx = cpu_addr[`SCC_IDX_LSB +: `SCC_IDX_W];
    assign cpu_off = cpu_addr[`SCC_OFF_LSB +: `SCC_OFF_W];
    assign cpu_tag = cpu_addr[`SCC_TAG_LSB +: `SCC_TAG_W];
    assign snp_idx = snp_addr[`SCC_IDX_LSB +: `SCC_IDX_W];
    assign snp_tag = snp_addr[`SCC_TAG_LSB +: `SCC_TAG_W];

    // --------------------
    // set contents for both lookups
    // --------------------
    logic [`SCC_WAYS*`SCC_TAG_W-1:0] cpu_tags;
    logic [`SCC_WAYS*`SCC_TAG_W-1:0] snp_tags;
    logic [`SCC_WAYS-1:0]            cpu_vld;
    logic [`SCC_WAYS-1:0]            cpu_drt;
    logic [`SCC_WAYS-1:0]            snp_vld;

    genvar g;
    generate
        for (g = 0; g < `SCC_WAYS; g++) begin : g_set
            assign cpu_tags[g*`SCC_TAG_W +: `SCC_TAG_W] = tag_r[g][cpu_idx];
            assign snp_tags[g*`SCC_TAG_W +: `SCC_TAG_W] = tag_r[g][snp_idx];
            assign cpu_vld[g] = valid_r[g][cpu_idx];
            assign cpu_drt[g] = dirty_r[g][cpu_idx];
            assign snp_vld[g] = valid_r[g][snp_idx];
        end
    endgenerate

    logic                  cpu_hit;
    logic [`SCC_WAY_W-1:0] cpu_way;
    logic                  snp_hit;
    logic [`SCC_WAY_W-1:0] snp_way;
    logic [`SCC_WAY_W-1:0] victim;

    // processor lookup, hit or miss
    scc_way_match u_cpu_match (
        .tags_flat (cpu_tags),
        .valid_vec (cpu_vld),
        .tag       (cpu_tag),
        .hit       (cpu_hit),
        .hit_way   (cpu_way)
    );

    // independent snoop lookup so it never waits on the processor
    scc_way_match u_snp_match (
        .tags_flat (snp_tags),
        .valid_vec (snp_vld),
        .tag       (snp_tag),
        .hit       (snp_hit),
        .hit_way   (snp_way)
    );

    // --------------------
    // decisions taken in idle and during write-back and fill
    // --------------------
    logic go;
    logic rd_hit;
    logic wr_hit;
    logic wt_miss;
    logic wt_start;
    logic alloc;
    logic need_wb;
    logic ack;
    logic wb_last;
    logic fill_ack;
    logic fill_done;
    logic snp_fill_hit;
    logic [`SCC_OFF_W-1:0] cnt_inc;

    assign go       = (state_r == scc_pkg::ST_IDLE) && cpu_req;
    assign rd_hit   = go && !cpu_we && cpu_hit;
    assign wr_hit   = go && cpu_we && cpu_hit;
    // write-through misses go straight to memory, no allocation
    assign wt_miss  = go && cpu_we && !cpu_hit && !policy_copy_back;
    assign wt_start = (wr_hit && !policy_copy_back) || wt_miss;
    // read misses, and copy-back write misses, allocate a line
    assign alloc    = go && !cpu_hit && !wt_miss;
    assign need_wb  = alloc && cpu_vld[victim] && cpu_drt[victim];
    assign ack      = mem_req_r && mem_ack;
    assign cnt_inc  = `SCC_OFF_W'(cnt_r + 1'b1);
    assign wb_last  = (state_r == scc_pkg::ST_WB) && ack && (cnt_r == `SCC_OFF_LAST);
    assign fill_ack = (state_r == scc_pkg::ST_FILL) && ack;
    assign fill_done = fill_ack && (cnt_r == `SCC_OFF_LAST);
    // a snoop on the line being fetched would otherwise be lost
    assign snp_fill_hit = snp_wr && (state_r == scc_pkg::ST_FILL)
                          && (snp_idx == lidx_r) && (snp_tag == ftag_r);

    // --------------------
    // replacement choice
    // --------------------
    scc_lru u_lru (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_n),
        .touch      (rd_hit || wr_hit || fill_done),
        .touch_idx  (fill_done ? lidx_r : cpu_idx),
        .touch_way  (fill_done ? vway_r : cpu_way),
        .look_idx   (cpu_idx),
        .look_valid (cpu_vld),
        .victim_way (victim)
    );

    // --------------------
    // control sequence
    // --------------------
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_r <= scc_pkg::ST_IDLE;
            cnt_r   <= `SCC_OFF_ZERO;
            vway_r  <= '0;
            lidx_r  <= '0;
            ftag_r  <= '0;
            stale_r <= 1'b0;
        end else begin
            case (state_r)
                scc_pkg::ST_IDLE: begin
                    if (rd_hit || (wr_hit && policy_copy_back)) begin
                        state_r <= scc_pkg::ST_DONE;
                    end else if (wt_start) begin
                        state_r <= scc_pkg::ST_WT;
                    end else if (alloc) begin
                        state_r <= need_wb ? scc_pkg::ST_WB : scc_pkg::ST_FILL;
                        cnt_r   <= `SCC_OFF_ZERO;
                        vway_r  <= victim;
                        lidx_r  <= cpu_idx;
                        ftag_r  <= cpu_tag;
                        stale_r <= 1'b0;
                    end
                end
                scc_pkg::ST_WT: begin
                    if (ack) begin
                        state_r <= scc_pkg::ST_DONE;
                    end
                end
                scc_pkg::ST_WB: begin
                    if (ack) begin
                        cnt_r <= cnt_inc;
                        if (cnt_r == `SCC_OFF_LAST) begin
                            state_r <= scc_pkg::ST_FILL;
                        end
                    end
                end
                scc_pkg::ST_FILL: begin
                    if (snp_fill_hit) begin
                        stale_r <= 1'b1;
                    end
                    if (ack) begin
                        cnt_r <= cnt_inc;
                        // back to idle, the held request now looks up again
                        if (cnt_r == `SCC_OFF_LAST) begin
                            state_r <= scc_pkg::ST_IDLE;
                        end
                    end
                end
                scc_pkg::ST_DONE: begin
                    state_r <= scc_pkg::ST_IDLE;
                end
                default: begin
                    state_r <= scc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // --------------------
    // memory bus master
    // --------------------
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mem_req_r   <= 1'b0;
            mem_we_r    <= 1'b0;
            mem_addr_r  <= '0;
            mem_wdata_r <= '0;
        end else if (wt_start) begin
            mem_req_r   <= 1'b1;
            mem_we_r    <= 1'b1;
            mem_addr_r  <= cpu_addr;
            mem_wdata_r <= cpu_wdata;
        end else if (need_wb) begin
            // old line goes out first, word 0 onward
            mem_req_r   <= 1'b1;
            mem_we_r    <= 1'b1;
            mem_addr_r  <= {tag_r[victim][cpu_idx], cpu_idx, `SCC_OFF_ZERO, `SCC_BYTE0};
            mem_wdata_r <= data_r[{victim, cpu_idx, `SCC_OFF_ZERO}];
        end else if (alloc) begin
            mem_req_r   <= 1'b1;
            mem_we_r    <= 1'b0;
            mem_addr_r  <= {cpu_tag, cpu_idx, `SCC_OFF_ZERO, `SCC_BYTE0};
        end else if (ack) begin
            case (state_r)
                scc_pkg::ST_WB: begin
                    if (cnt_r == `SCC_OFF_LAST) begin
                        mem_we_r   <= 1'b0;
                        mem_addr_r <= {ftag_r, lidx_r, `SCC_OFF_ZERO, `SCC_BYTE0};
                    end else begin
                        mem_addr_r[`SCC_OFF_LSB +: `SCC_OFF_W] <= cnt_inc;
                        mem_wdata_r <= data_r[{vway_r, lidx_r, cnt_inc}];
                    end
                end
                scc_pkg::ST_FILL: begin
                    if (cnt_r == `SCC_OFF_LAST) begin
                        mem_req_r <= 1'b0;
                    end else begin
                        mem_addr_r[`SCC_OFF_LSB +: `SCC_OFF_W] <= cnt_inc;
                    end
                end
                default: begin
                    mem_req_r <= 1'b0;
                end
            endcase
        end
    end

    // --------------------
    // line status per way
    // --------------------
    generate
        for (g = 0; g < `SCC_WAYS; g++) begin : g_stat
            // snoop clear is written last so it wins over a fill
            always_ff @(posedge clk_sys or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    valid_r[g] <= '0;
                end else begin
                    if (fill_done && (vway_r == g)) begin
                        valid_r[g][lidx_r] <= !stale_r && !snp_fill_hit;
                    end
                    if (snp_wr && snp_hit && (snp_way == g)) begin
                        valid_r[g][snp_idx] <= 1'b0;
                    end
                end
            end

            // modified only by copy-back write hits, cleared by refill
            always_ff @(posedge clk_sys or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    dirty_r[g] <= '0;
                end else if (fill_done && (vway_r == g)) begin
                    dirty_r[g][lidx_r] <= 1'b0;
                end else if (wr_hit && policy_copy_back && (cpu_way == g)) begin
                    dirty_r[g][cpu_idx] <= 1'b1;
                end
            end

            // tags need no reset, valid bits guard them
            always_ff @(posedge clk_sys) begin
                if (fill_done && (vway_r == g)) begin
                    tag_r[g][lidx_r] <= ftag_r;
                end
            end
        end
    endgenerate

    // --------------------
    // data store
    // --------------------
    // whole-word writes only; the processor bus has no byte enables
    always_ff @(posedge clk_sys) begin
        if (wr_hit) begin
            data_r[{cpu_way, cpu_idx, cpu_off}] <= cpu_wdata;
        end else if (fill_ack) begin
            data_r[{vway_r, lidx_r, cnt_r}] <= mem_rdata;
        end
    end

    // read hit data captured for the ready cycle
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cpu_rdata_r <= '0;
        end else if (rd_hit) begin
            cpu_rdata_r <= data_r[{cpu_way, cpu_idx, cpu_off}];
        end
    end

    // --------------------
    // outputs
    // --------------------
    assign cpu_ready = (state_r == scc_pkg::ST_DONE);
    assign cpu_rdata = cpu_rdata_r;
    assign mem_req   = mem_req_r;
    assign mem_we    = mem_we_r;
    assign mem_addr  = mem_addr_r;
    assign mem_wdata = mem_wdata_r;
endmodule

// file: scc_ctrl_assertions.sv
`timescale 1ns/10ps
`include "scc_params.svh"
module scc_ctrl_assertions (
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                policy_copy_back,
    input wire logic                cpu_req,
    input wire logic                cpu_we,
    input wire logic [`SCC_AW-1:0]  cpu_addr,
    input wire logic [`SCC_DW-1:0]  cpu_wdata,
    input wire logic                cpu_ready,
    input wire logic                mem_req,
    input wire logic                mem_we,
    input wire logic [`SCC_AW-1:0]  mem_addr,
    input wire logic [`SCC_DW-1:0]  mem_wdata,
    input wire logic                mem_ack
);
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ---------------------
    // memory bus word steps
    // ---------------------
    sequence s_fill_mid;
        mem_req && !mem_we && mem_ack && mem_addr[3:2] != 2'h3;
    endsequence
    sequence s_fill_last;
        mem_req && !mem_we && mem_ack && mem_addr[3:2] == 2'h3;
    endsequence
    // write-back words only gated in copy-back mode; a policy flip leaves old dirty lines unchecked
    sequence s_wb_mid;
        policy_copy_back && mem_req && mem_we && mem_ack && mem_addr[3:2] != 2'h3;
    endsequence
    sequence s_wb_last;
        policy_copy_back && mem_req && mem_we && mem_ack && mem_addr[3:2] == 2'h3;
    endsequence
    sequence s_wt_ack;
        cpu_req && cpu_we && !policy_copy_back && mem_req && mem_we && mem_ack;
    endsequence
    property p_fill_step;
        s_fill_mid |=> mem_req && !mem_we && mem_addr == $past(mem_addr) + 32'h4;
    endproperty
    property p_fill_end;
        s_fill_last |=> !mem_req ##1 (cpu_ready || mem_req);
    endproperty
    property p_wb_step;
        s_wb_mid |=> mem_req && mem_we && mem_addr == $past(mem_addr) + 32'h4;
    endproperty
    property p_wb_fill;
        s_wb_last |=> mem_req && !mem_we && mem_addr[3:0] == 4'h0;
    endproperty
    property p_line_base;
        $rose(mem_req) && !(mem_we && !policy_copy_back) |-> mem_addr[3:0] == 4'h0;
    endproperty
    property p_mem_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
    endproperty
    property p_wt_word;
        cpu_req && cpu_we && !policy_copy_back && mem_req |-> mem_we && mem_addr == cpu_addr
            && mem_wdata == cpu_wdata;
    endproperty
    property p_wt_done;
        s_wt_ack |=> cpu_ready;
    endproperty
    property p_cb_quiet;
        cpu_ready && cpu_we && policy_copy_back |-> !mem_req && !$past(mem_req);
    endproperty
    property p_ready_once;
        cpu_ready |=> !cpu_ready;
    endproperty
    property p_answer;
        $rose(cpu_req) |-> ##[1:300] cpu_ready;
    endproperty
    a_fill_step: assert property (p_fill_step) else $error("fill word order broken");
    a_fill_end: assert property (p_fill_end) else $error("no retake after fill");
    a_wb_step: assert property (p_wb_step) else $error("write-back word order broken");
    a_wb_fill: assert property (p_wb_fill) else $error("refill does not follow write-back");
    a_line_base: assert property (p_line_base) else $error("line burst not at word 0");
    a_mem_hold: assert property (p_mem_hold) else $error("memory request moved before ack");
    a_wt_word: assert property (p_wt_word) else $error("write-through word wrong");
    a_wt_done: assert property (p_wt_done) else $error("write-through not released");
    a_cb_quiet: assert property (p_cb_quiet) else $error("copy-back write used memory");
    a_ready_once: assert property (p_ready_once) else $error("ready longer than one cycle");
    a_answer: assert property (p_answer) else $error("request never answered");
endmodule
bind scc_ctrl scc_ctrl_assertions scc_ctrl_assertions_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .policy_copy_back(policy_copy_back), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack));

// file: scc_mem_model.sv
`timescale 1ns/10ps
module scc_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic        snp_wr,
    input  wire logic [31:0] snp_addr,
    input  wire logic [31:0] snp_data,
    input  wire logic [1:0]  lat,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata,
    output int               n_rd,
    output int               n_wr
);
    logic [31:0] store [int];
    int          cnt;
    // ack after lat waits; read data toggles off the ack cycle so stale use shows up
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
            cnt <= 0;
            n_rd <= 0;
            n_wr <= 0;
        end else begin
            if (snp_wr)
                store[int'(snp_addr[31:2])] = snp_data;
            if (mem_req && !mem_ack && cnt >= int'(lat)) begin
                mem_ack <= 1'b1;
                cnt <= 0;
                if (mem_we) begin
                    store[int'(mem_addr[31:2])] = mem_wdata;
                    n_wr <= n_wr + 1;
                end else begin
                    n_rd <= n_rd + 1;
                    if (store.exists(int'(mem_addr[31:2])))
                        mem_rdata <= store[int'(mem_addr[31:2])];
                    else
                        mem_rdata <= {mem_addr[31:2], 2'h0} ^ 32'hC3C3_0000;
                end
            end else begin
                mem_ack <= 1'b0;
                mem_rdata <= ~mem_rdata;
                cnt <= mem_req ? cnt + 1 : 0;
            end
        end
    end
endmodule

// file: scc_ctrl_tb.sv
`timescale 1ns/10ps
`include "scc_params.svh"
module scc_ctrl_tb;
    logic        clk_sys, rst_n, policy_copy_back, cpu_req, cpu_we, cpu_ready;
    logic        mem_req, mem_we, mem_ack, snp_wr, snp_en;
    logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, mem_addr, mem_wdata, mem_rdata, snp_addr, snp_data;
    logic [1:0]  mem_lat;
    int          n_rd, n_wr, failures, num_checks, seed, lat, r0, w0, i;
    logic [31:0] ref_mem [int];

    scc_ctrl scc_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .policy_copy_back(policy_copy_back),
        .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .snp_wr(snp_wr), .snp_addr(snp_addr));
    scc_mem_model scc_mem_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .snp_wr(snp_wr),
        .snp_addr(snp_addr), .snp_data(snp_data), .lat(mem_lat), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .n_rd(n_rd), .n_wr(n_wr));

    // free-running 50 MHz clock
    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;

    // ------------------------
    // reference and bus tasks
    // ------------------------
    function automatic logic [31:0] mk(input int t, input int s, input int w);
        return {t[23:0], s[3:0], w[1:0], 2'h0};
    endfunction
    function automatic logic [31:0] expect_rd(input logic [31:0] a);
        if (ref_mem.exists(int'(a[31:2])))
            return ref_mem[int'(a[31:2])];
        return {a[31:2], 2'h0} ^ 32'hC3C3_0000;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one processor access; negative counts mean do not care
    task automatic acc(input logic we, input logic cb, input logic [31:0] a, input logic [31:0] d,
                       input int el, input int er, input int ew);
        @(posedge clk_sys);
        cpu_req <= 1'b1;
        cpu_we <= we;
        cpu_addr <= a;
        cpu_wdata <= d;
        policy_copy_back <= cb;
        mem_lat <= 2'($random(seed));
        r0 = n_rd;
        w0 = n_wr;
        lat = 0;
        do begin
            @(negedge clk_sys);
            lat++;
        end while (cpu_ready !== 1'b1 && lat < 400);
        check(32'(lat < 400), 32'h1);
        if (!we)
            check(cpu_rdata, expect_rd(a));
        else
            ref_mem[int'(a[31:2])] = d;
        if (el >= 0) check(32'(lat), 32'(el));
        if (er >= 0) check(32'(n_rd - r0), 32'(er));
        if (ew >= 0) check(32'(n_wr - w0), 32'(ew));
        @(posedge clk_sys);
        cpu_req <= 1'b0;
    endtask
    task automatic snoop(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        snp_wr <= 1'b1;
        snp_addr <= a;
        snp_data <= d;
        ref_mem[int'(a[31:2])] = d;
        @(posedge clk_sys);
        snp_wr <= 1'b0;
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // foreign writes only mid-fill, so no read hit races an invalidate
    always @(posedge clk_sys) begin
        if (snp_en) begin
            if (mem_req === 1'b1 && mem_we === 1'b0 && mem_ack === 1'b0 && mem_addr[3:2] != 2'h3
                && $random(seed) % 2 == 0) begin
                snp_wr <= 1'b1;
                snp_addr <= mk(16 + ($random(seed) & 3), $random(seed) & 1, $random(seed) & 3);
                snp_data <= $random(seed);
            end else
                snp_wr <= 1'b0;
        end
    end
    // reference takes the snoop data as launched
    always @(negedge clk_sys) begin
        if (snp_en && snp_wr === 1'b1)
            ref_mem[int'(snp_addr[31:2])] = snp_data;
    end

    // hang guard, far beyond the expected run
    initial begin
        #800000;
        failures++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        final_report();
    end

    // ---------------
    // main sequence
    // ---------------
    initial begin
        seed = 67;
        failures = 0;
        num_checks = 0;
        snp_en = 1'b0;
        rst_n = 1'b0;
        {cpu_req, cpu_we, policy_copy_back, snp_wr} = 4'h0;
        {cpu_addr, cpu_wdata, snp_addr, snp_data} = 128'h0;
        mem_lat = 2'h1;
        repeat (7) @(posedge clk_sys);
        @(negedge clk_sys);
        check({29'h0, cpu_ready, mem_req, mem_we}, 32'h0);
        check(mem_addr | mem_wdata | cpu_rdata, 32'h0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        acc(0, 0, mk(1, 3, 0), 0, -1, 4, 0);
        acc(0, 0, mk(1, 3, 2), 0, 2, 0, 0);
        acc(1, 0, mk(1, 3, 1), 32'h1111_AAAA, -1, 0, 1);
        acc(0, 0, mk(1, 3, 1), 0, 2, 0, 0);
        acc(1, 1, mk(1, 3, 2), 32'h2222_BBBB, 2, 0, 0);
        acc(0, 1, mk(2, 3, 0), 0, -1, 4, 0);
        acc(0, 1, mk(3, 3, 0), 0, -1, 4, 4);
        acc(0, 1, mk(1, 3, 2), 0, -1, 4, 0);
        acc(1, 1, mk(4, 3, 0), 32'h3333_CCCC, -1, 4, 0);
        snoop(mk(1, 3, 3), 32'h4444_DDDD);
        acc(0, 0, mk(1, 3, 3), 0, -1, 4, 0);
        acc(1, 0, mk(5, 3, 0), 32'h5555_EEEE, -1, 0, 1);
        acc(0, 0, mk(5, 3, 0), 0, -1, 4, 4);
        for (i = 0; i < 300; i++) begin
            snp_en = i >= 150;
            acc(1'($random(seed)), i < 150 && 1'($random(seed)), mk((i < 150 ? 8 : 16) + ($random(seed) & 3),
                $random(seed) & 1, $random(seed) & 3), $random(seed), -1, -1, -1);
        end
        @(posedge clk_sys);
        snp_en = 1'b0;
        final_report();
    end
endmodule
